/* File: hw/rsl_line_mode.sv */
// top: line-mode control for serial channels plus run indicator
`timescale 1ns/1ps
`include "rsl_defs.svh"
// Overview of operation
// R01 - In rs485 the channel works half duplex on a bus shared by several stations.
// R02 - In rs485 the receiver hears its own transmission unless echo suppression is set.
// R03 - In rs485 with echo suppression set, no new data is accepted while a transmission is in progress.
// R04 - Suppress 0, full duplex 0 gives rs485 hearing both own and foreign data.
// R05 - Suppress 0, full duplex 1 gives rs422 with transmitter and receiver concurrent.
// R06 - Suppress 1, full duplex 0 gives rs485 passing only foreign data.
// R07 - Both bits 1 gives rs422 with the receiver enabled only after the last data is sent.
// R08 - The run indicator is off, flashing, single flash or on by fieldbus state.
// R09 - Each channel drives its own transmit activity indicator.
// R10 - Each channel drives its own receive activity indicator.
// R11 - Installers should keep an rs422 link to one receiver, about ten at most.
// R12 - Mode bits apply per channel and gating holds still during a character.
module rsl_line_mode
  import rsl_pkg::*;
#(
  parameter int unsigned NCH = 2,
  parameter int unsigned FLASH_CYC = `RSL_FLASH_CYC,
  parameter int unsigned SINGLE_CYC = `RSL_SINGLE_CYC,
  parameter int unsigned HOLD_CYC = `RSL_LED_HOLD_CYC
) (
  input wire logic mclk, // 40 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire rsl_mode_s [NCH-1:0] mode, // per-channel mode bits
  input wire logic [NCH-1:0] tx_busy, // transmitter sending
  input wire logic [NCH-1:0] tx_pending, // transmit data queued
  input wire logic [NCH-1:0] rx_pin, // receive line pin, async
  input wire logic [NCH-1:0] rx_char_busy, // receiver inside a character
  input wire logic [NCH-1:0] rx_valid, // receiver character ready
  input wire rsl_fsm_e fsm_state, // fieldbus state
  output logic [NCH-1:0] rx_line_gated, // gated line to receiver
  output logic [NCH-1:0] rx_accept, // character passed on
  output logic [NCH-1:0] tx_activity_led, // transmit indicators
  output logic [NCH-1:0] rx_activity_led, // receive indicators
  output logic run_led // run indicator
);
  logic [NCH-1:0] s1_q;
  logic [NCH-1:0] s2_q;
  logic [NCH-1:0] s3_q;
  logic [NCH-1:0] rx_clean_q;
  logic [`RSL_CNT_W-1:0] blink_q;
  logic run_led_q;

  // pin sampled three deep; change taken once stages two and three agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= rx_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_clean_q <= '1;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          rx_clean_q[i] <= s3_q[i];
        end
      end
    end
  end

  // R12 per-channel gating
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    rsl_rx_gate #(
      .HOLD_CYC(HOLD_CYC)
    ) u_gate (
      .mclk(mclk),
      .nrst(nrst),
      .mode(mode[g]),
      .tx_busy(tx_busy[g]),
      .tx_pending(tx_pending[g]),
      .rx_line(rx_clean_q[g]),
      .rx_char_busy(rx_char_busy[g]),
      .rx_valid(rx_valid[g]),
      .rx_line_gated(rx_line_gated[g]),
      .rx_accept(rx_accept[g]),
      .tx_activity_led(tx_activity_led[g]),
      .rx_activity_led(rx_activity_led[g])
    );
  end

  // blink timebase; single flash period wraps the counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      blink_q <= '0;
    end else if (blink_q >= `RSL_CNT_W'(SINGLE_CYC - 1)) begin
      blink_q <= '0;
    end else begin
      blink_q <= blink_q + 1'b1;
    end
  end

  // R08 run indicator
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_led_q <= 1'b0;
    end else begin
      unique case (fsm_state)
        rsl_st_init, rsl_st_firmware_load: run_led_q <= 1'b0;
        rsl_st_pre_operational: run_led_q <= ((blink_q / `RSL_CNT_W'(FLASH_CYC)) % 2) == 0;
        rsl_st_safe_operational: run_led_q <= blink_q < `RSL_CNT_W'(FLASH_CYC);
        rsl_st_operational: run_led_q <= 1'b1;
        default: run_led_q <= 1'b0;
      endcase
    end
  end

  assign run_led = run_led_q;
endmodule

/* File: hw/rsl_defs.svh */
// shared constants for the rs422/rs485 line-mode block
`ifndef RSL_DEFS_SVH
`define RSL_DEFS_SVH
`define RSL_CLK_HZ 40000000
`define RSL_FLASH_MS 200
`define RSL_FLASH_CYC ((`RSL_CLK_HZ / 1000) * `RSL_FLASH_MS)
`define RSL_SINGLE_MS 1000
`define RSL_SINGLE_CYC ((`RSL_CLK_HZ / 1000) * `RSL_SINGLE_MS)
`define RSL_LED_HOLD_MS 50
`define RSL_LED_HOLD_CYC ((`RSL_CLK_HZ / 1000) * `RSL_LED_HOLD_MS)
`define RSL_CNT_W 32
`endif

/* File: hw/rsl_pkg.sv */
// types for the rs422/rs485 line-mode block
package rsl_pkg;
  typedef enum logic [2:0] {
    rsl_st_init,
    rsl_st_firmware_load,
    rsl_st_pre_operational,
    rsl_st_safe_operational,
    rsl_st_operational
  } rsl_fsm_e;
  typedef struct packed {
    logic echo_suppress;
    logic full_duplex_select;
  } rsl_mode_s;
  typedef enum logic [1:0] {
    rsl_m_485_echo,
    rsl_m_422_duplex,
    rsl_m_485_quiet,
    rsl_m_422_after_tx
  } rsl_mode_e;
endpackage

/* File: hw/rsl_rx_gate.sv */
// per-channel receive gating and activity indicators
`timescale 1ns/1ps
`include "rsl_defs.svh"
module rsl_rx_gate
  import rsl_pkg::*;
#(
  parameter int unsigned HOLD_CYC = `RSL_LED_HOLD_CYC
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // async reset, active low
  input wire rsl_mode_s mode, // mode bits for this channel
  input wire logic tx_busy, // transmitter is sending
  input wire logic tx_pending, // transmit data still queued
  input wire logic rx_line, // received line level, synchronised
  input wire logic rx_char_busy, // receiver is inside a character
  input wire logic rx_valid, // receiver has a character
  output logic rx_line_gated, // line level passed to the receiver
  output logic rx_accept, // character passed on
  output logic tx_activity_led, // transmit activity indicator
  output logic rx_activity_led // receive activity indicator
);
  rsl_mode_e live_mode;
  rsl_mode_e mode_q;
  logic [`RSL_CNT_W-1:0] tx_hold_q;
  logic [`RSL_CNT_W-1:0] rx_hold_q;
  logic rx_enable;
  logic tx_any;

  assign live_mode = rsl_mode_e'({mode.echo_suppress, mode.full_duplex_select});
  assign tx_any = tx_busy | tx_pending;

  // R12 hold mid-char
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= rsl_m_485_echo;
    end else if (!rx_char_busy && !tx_busy) begin
      mode_q <= live_mode;
    end
  end

  always_comb begin
    unique case (mode_q)
      // R04 own echo heard
      rsl_m_485_echo: rx_enable = 1'b1;
      // R05 full duplex
      rsl_m_422_duplex: rx_enable = 1'b1;
      // R02 R06 echo suppressed
      rsl_m_485_quiet: rx_enable = !tx_busy;
      // R07 after last tx
      rsl_m_422_after_tx: rx_enable = !tx_any;
    endcase
  end

  // R01 R03 half duplex lockout
  assign rx_line_gated = rx_enable ? rx_line : 1'b1;
  assign rx_accept = rx_valid && rx_enable;

  // R09 tx led stretch
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_hold_q <= '0;
    end else if (tx_busy) begin
      tx_hold_q <= `RSL_CNT_W'(HOLD_CYC);
    end else if (tx_hold_q != '0) begin
      tx_hold_q <= tx_hold_q - 1'b1;
    end
  end

  // R10 rx led stretch
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_hold_q <= '0;
    end else if (rx_enable && (rx_char_busy || rx_valid)) begin
      rx_hold_q <= `RSL_CNT_W'(HOLD_CYC);
    end else if (rx_hold_q != '0) begin
      rx_hold_q <= rx_hold_q - 1'b1;
    end
  end

  assign tx_activity_led = tx_hold_q != '0;
  assign rx_activity_led = rx_hold_q != '0;
endmodule

/* File: sim/rsl_line_mode_sva.sv */
// assertions for the line-mode block
`timescale 1ns/1ps
module rsl_line_mode_sva
  import rsl_pkg::*;
#(parameter int unsigned NCH = 2) (
  input wire logic mclk, // clock
  input wire logic nrst, // reset
  input wire rsl_mode_s [NCH-1:0] mode, // in
  input wire logic [NCH-1:0] tx_busy, // in
  input wire logic [NCH-1:0] tx_pending, // in
  input wire logic [NCH-1:0] rx_char_busy, // in
  input wire logic [NCH-1:0] rx_valid, // in
  input wire rsl_fsm_e fsm_state, // in
  input wire logic [NCH-1:0] rx_line_gated, // out
  input wire logic [NCH-1:0] rx_accept, // out
  input wire logic [NCH-1:0] tx_activity_led, // out
  input wire logic [NCH-1:0] rx_activity_led, // out
  input wire logic run_led // out
);
  rsl_mode_s [NCH-1:0] lat_q;
  logic [NCH-1:0] en;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // shadow of the mode latch, only taken between characters
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) lat_q <= '0;
    else for (int i = 0; i < NCH; i++) if (!rx_char_busy[i] && !tx_busy[i]) lat_q[i] <= mode[i];
  end
  always_comb begin
    for (int i = 0; i < NCH; i++)
      en[i] = !lat_q[i].echo_suppress || !tx_busy[i] && !(lat_q[i].full_duplex_select && tx_pending[i]);
  end
  accept_gate_a: assert property (rx_accept == (rx_valid & en)) else $error("gate");
  echo_hear_a: assert property (lat_q[0] == 2'b00 |-> rx_accept[0] == rx_valid[0]) else $error("m0");
  duplex_open_a: assert property (lat_q[1] == 2'b01 |-> rx_accept[1] == rx_valid[1]) else $error("m1");
  echo_drop_a: assert property (lat_q[0] == 2'b10 && tx_busy[0] |-> !rx_accept[0]) else $error("m2");
  after_tx_a: assert property (lat_q[0] == 2'b11 && tx_pending[0] |-> !rx_accept[0]) else $error("m3");
  line_hold_a: assert property (!en[0] |-> rx_line_gated[0]) else $error("line");
  tx_led_a: assert property (tx_busy[0] |=> tx_activity_led[0] [*2]) else $error("txled");
  rx_led_a: assert property (rx_accept[0] |=> rx_activity_led[0]) else $error("rxled");
  run_on_a: assert property (fsm_state == rsl_st_operational [*2] |-> run_led) else $error("on");
  run_off_a: assert property (fsm_state == rsl_st_firmware_load [*2] |-> !run_led) else $error("off");
  cover property (lat_q[0] == 2'b10 && tx_busy[0] && rx_valid[0]);
  cover property (lat_q[0] == 2'b11 && tx_pending[0] && !tx_busy[0]);
  cover property (run_led && fsm_state == rsl_st_safe_operational);
endmodule
bind rsl_line_mode rsl_line_mode_sva #(.NCH(NCH)) rsl_line_mode_sva_inst(.mclk(mclk), .nrst(nrst),
  .mode(mode), .tx_busy(tx_busy), .tx_pending(tx_pending), .rx_char_busy(rx_char_busy),
  .rx_valid(rx_valid), .fsm_state(fsm_state), .rx_line_gated(rx_line_gated),
  .rx_accept(rx_accept), .tx_activity_led(tx_activity_led), .rx_activity_led(rx_activity_led),
  .run_led(run_led));

/* File: sim/rsl_far_station.sv */
// far-side station: drives the receive line, resting high when silent
`timescale 1ns/1ps
module rsl_far_station #(parameter int unsigned NCH = 2) (
  input wire logic mclk, // system clock
  input wire logic [NCH-1:0] talk, // station sends on this channel
  output logic [NCH-1:0] line // receive line seen by the device
);
  initial line = '1;
  // single sender; terminated line idles high
  always @(posedge mclk) line <= #1 ~talk | NCH'($urandom);
endmodule

/* File: sim/tb_top.sv */
// bench for the line-mode block: random gating traffic and run indicator
`timescale 1ns/1ps
module tb_top;
  import rsl_pkg::*;
  logic mclk = 0;
  logic nrst = 0;
  rsl_mode_s [1:0] mode = '0;
  logic [1:0] tx_busy = 0, tx_pending = 0, rx_char_busy = 0, rx_valid = 0, talk = 0, rx_pin;
  logic [1:0] rx_line_gated, rx_accept, tx_activity_led, rx_activity_led;
  logic run_led;
  rsl_fsm_e fsm_state = rsl_st_init;
  logic [1:0] q[$];
  logic [1:0] qg[$];
  logic [1:0] txp = 0, rap = 0, ge;
  int n_mismatch = 0, n_compared = 0, cyc = 0, n;
  always #12.5 mclk = ~mclk;
  rsl_line_mode #(.NCH(2), .FLASH_CYC(8), .SINGLE_CYC(32), .HOLD_CYC(4)) rsl_line_mode_inst(
    .mclk(mclk), .nrst(nrst), .mode(mode), .tx_busy(tx_busy), .tx_pending(tx_pending),
    .rx_pin(rx_pin), .rx_char_busy(rx_char_busy), .rx_valid(rx_valid), .fsm_state(fsm_state),
    .rx_line_gated(rx_line_gated), .rx_accept(rx_accept), .tx_activity_led(tx_activity_led),
    .rx_activity_led(rx_activity_led), .run_led(run_led));
  rsl_far_station rsl_far_station_inst(.mclk(mclk), .talk(talk), .line(rx_pin));
  task cmp(string what, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (e !== s) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(negedge mclk) begin
    if (q.size() > 0) begin
      // leds must be lit one edge after the activity noted a cycle ago
      cmp("tx_led", 8'(txp), 8'(tx_activity_led & txp));
      cmp("rx_led", 8'(rap), 8'(rx_activity_led & rap));
      rap = q[0];
      txp = tx_busy;
      cmp("rx_accept", 8'(q.pop_front()), 8'(rx_accept));
      ge = qg.pop_front();
      cmp("rx_line_gated", 8'h03, 8'(rx_line_gated | ge));
    end
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    void'($urandom(20));
    repeat (8) @(posedge mclk);
    #1 nrst = 1;
    // channels get different modes so each must gate alone
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      #1 {tx_busy, tx_pending, rx_char_busy} = '0;
      mode[0] = rsl_mode_s'(m[1:0]);
      mode[1] = rsl_mode_s'(~m[1:0]);
      talk = 2'($urandom);
      repeat (2) @(posedge mclk);
      repeat (24) begin
        @(posedge mclk);
        #1 {tx_busy, tx_pending, rx_char_busy, rx_valid} = 8'($urandom);
        for (int i = 0; i < 2; i++) begin
          ge[i] = !mode[i][1] | !tx_busy[i] & !(mode[i][0] & tx_pending[i]);
          n[i] = rx_valid[i] & ge[i];
        end
        q.push_back(n[1:0]);
        qg.push_back(ge);
      end
    end
    fsm_state = rsl_st_firmware_load;
    repeat (3) @(posedge mclk);
    #1 cmp("run_off", 8'h00, 8'(run_led));
    fsm_state = rsl_st_operational;
    repeat (3) @(posedge mclk);
    #1 cmp("run_on", 8'h01, 8'(run_led));
    // flashing then single flash: on-time over one 32-cycle window
    for (int k = 0; k < 2; k++) begin
      fsm_state = k ? rsl_st_safe_operational : rsl_st_pre_operational;
      repeat (40) @(posedge mclk);
      n = 0;
      repeat (32) begin
        @(posedge mclk);
        #1 n += run_led;
      end
      cmp("run_flash", k ? 8'h08 : 8'h10, 8'(n));
    end
    test_done();
  end
endmodule
